// *** include/lcdpc_pkg.sv ***
/*
 * lcdpc_pkg: constants for the lcd phase control register block.
 * assumes a classic wishbone slave with 32-bit data on a 100 MHz clock.
 */
// Function
// - bit 7 picks type-B frame or type-A common phase
// - active flag reads 1 while driver operates
// - write-allow flag 1 only when segment writes permitted
// - lcd clock divided by prescale field plus one
package lcdpc_pkg;
	// ==========================================
	// register map
	localparam logic [3:0] LCDPC_PHASE_CTRL_OFS = 4'h0;
	localparam logic [3:0] LCDPC_DRV_CTRL_OFS = 4'h4;
	localparam logic [7:0] LCDPC_PHASE_RESET = 8'h00;
	localparam logic [7:0] LCDPC_DRV_RESET = 8'h00;
	// ==========================================
	// field positions
	localparam int LCDPC_WFT_BIT = 7;
	localparam int LCDPC_BIAS_BIT = 6;
	localparam int LCDPC_ACTIVE_BIT = 5;
	localparam int LCDPC_WALLOW_BIT = 4;
	localparam int LCDPC_PRESC_MSB = 3;
	localparam int LCDPC_EN_BIT = 0;
	localparam int LCDPC_MUX_LSB = 1;
	localparam int LCDPC_COMMONS_MAX = 4;
	localparam logic [1:0] LCDPC_COM_RESET = 2'h0;
	localparam logic [3:0] LCDPC_PRESC_RESET = 4'h0;
endpackage

// *** include/lcdpc_tick_if.sv ***
/*
 * lcdpc_tick_if: prescaler settings and tick between lcdpc modules.
 * assumes one clock domain.
 */
`timescale 1ns/100ps
interface lcdpc_tick_if;
	logic run;
	logic [3:0] ratio;
	logic tick;
	modport ctrl (output run, output ratio, input tick);
	modport div (input run, input ratio, output tick);
endinterface

// *** rtl/lcdpc_prescaler.sv ***
/*
 * lcdpc_prescaler: divides the lcd clock enable by ratio plus one.
 * assumes ce_i gates all state.
 */
`timescale 1ns/100ps
module lcdpc_prescaler
	import lcdpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	lcdpc_tick_if.div tif
);
	logic [3:0] cnt_q;
	wire logic at_end = (cnt_q >= tif.ratio);
	// ==========================================
	// divide by ratio+1, ratio is compared every cycle so a change takes effect at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= LCDPC_PRESC_RESET;
		end else if (ce_i) begin
			if (!tif.run || at_end) begin
				cnt_q <= LCDPC_PRESC_RESET;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
	assign tif.tick = tif.run && at_end;
endmodule

// *** rtl/lcdpc_top.sv ***
/*
 * lcdpc_top: lcd phase control register with wishbone slave,
 * prescaler, common/phase sequencer and segment write gate.
 * assumes a classic wishbone master on clk_i; rst_i synchronous.
 */
`timescale 1ns/100ps
module lcdpc_top
	import lcdpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic lcd_tick_o,
	output logic [1:0] com_index_o,
	output logic phase_o,
	output logic frame_start_o,
	output logic seg_write_allow_o
);
	logic [7:0] phase_ctrl_q;
	logic drv_en_q;
	logic [1:0] mux_q;
	logic ack_q;
	logic [1:0] com_q;
	logic phase_q;
	logic active_q;
	logic frame_q;
	lcdpc_tick_if tif ();
	// ==========================================
	// bus decode
	wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
	wire logic sel_phase = (wb_adr_i == LCDPC_PHASE_CTRL_OFS);
	wire logic sel_drv = (wb_adr_i == LCDPC_DRV_CTRL_OFS);
	wire logic wr_phase = req && wb_we_i && sel_phase && wb_sel_i[0];
	wire logic wr_drv = req && wb_we_i && sel_drv && wb_sel_i[0];
	wire logic [1:0] com_last = mux_q;
	wire logic last_com = (com_q == com_last);
	wire logic [7:0] phase_rd = {phase_ctrl_q[7:6], active_q, seg_write_allow_o, phase_ctrl_q[3:0]};
	wire logic [7:0] drv_rd = {5'h00, mux_q, drv_en_q};
	wire logic [7:0] rd_byte = sel_phase ? phase_rd : (sel_drv ? drv_rd : 8'h00);
	// ==========================================
	// registers; status bits 5 and 4 are never stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_ctrl_q <= LCDPC_PHASE_RESET;
			drv_en_q <= 1'b0;
			mux_q <= LCDPC_COM_RESET;
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q <= req;
			if (req) begin
				wb_dat_o <= {24'h00_0000, rd_byte};
			end
			if (wr_phase) begin
				phase_ctrl_q <= {wb_dat_i[7:6], 2'b00, wb_dat_i[3:0]};
			end
			if (wr_drv) begin
				drv_en_q <= wb_dat_i[LCDPC_EN_BIT];
				mux_q <= wb_dat_i[2:1];
			end
		end
	end
	assign wb_ack_o = ack_q;
	// ==========================================
	// prescaler
	// keep ticking after disable so the frame in flight can finish and active_q can fall
	assign tif.run = drv_en_q || active_q;
	assign tif.ratio = phase_ctrl_q[LCDPC_PRESC_MSB:0];
	lcdpc_prescaler u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tif(tif)
	);
	// ==========================================
	// common/phase sequencer; driver only stops at frame end
	// so glass never sees a half-driven frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			com_q <= LCDPC_COM_RESET;
			phase_q <= 1'b0;
			active_q <= 1'b0;
			frame_q <= 1'b0;
		end else if (ce_i) begin
			frame_q <= 1'b0;
			if (!active_q) begin
				// phase is kept while idle so it only ever moves on a tick
				active_q <= drv_en_q;
				com_q <= LCDPC_COM_RESET;
			end else if (tif.tick) begin
				if (phase_ctrl_q[LCDPC_WFT_BIT]) begin
					// type-B: one phase across all commons, phase flips at frame end
					if (last_com) begin
						com_q <= LCDPC_COM_RESET;
						phase_q <= !phase_q;
						frame_q <= 1'b1;
						active_q <= drv_en_q;
					end else begin
						com_q <= com_q + 2'h1;
					end
				end else begin
					// type-A: phase flips inside each common slot
					phase_q <= !phase_q;
					if (phase_q) begin
						if (last_com) begin
							com_q <= LCDPC_COM_RESET;
							frame_q <= 1'b1;
							active_q <= drv_en_q;
						end else begin
							com_q <= com_q + 2'h1;
						end
					end
				end
			end
		end
	end
	assign lcd_tick_o = tif.tick;
	assign com_index_o = com_q;
	assign phase_o = phase_q;
	assign frame_start_o = frame_q;
	// segment data may be written while idle, or in the frame-boundary cycle of either type
	assign seg_write_allow_o = !active_q || frame_q;
	// bias bit is software's duty, used as-is
	wire logic bias_half_unused = phase_ctrl_q[LCDPC_BIAS_BIT];
endmodule

// *** sim/lcdpc_glass_model.sv ***
/* lcdpc_glass_model: glass stand-in that times the gap between lcd ticks.
   assumes tick_i comes from lcd_tick_o on the same clock. */
`timescale 1ns/100ps
module lcdpc_glass_model(
	input wire logic clk_i,
	input wire logic tick_i,
	output logic [7:0] gap_o
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk_i) begin
		cnt_q <= tick_i ? 8'h01 : cnt_q + 8'h01;
		if (tick_i) gap_o <= cnt_q;
	end
endmodule

// *** sim/lcdpc_checker.sv ***
/* lcdpc_checker: port assertions for lcdpc_top.
   assumes one clock and a bind onto lcdpc_top. */
`timescale 1ns/100ps
module lcdpc_checker(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic lcd_tick_o,
	input wire logic [1:0] com_index_o,
	input wire logic phase_o,
	input wire logic frame_start_o,
	input wire logic seg_write_allow_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack;
		wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	property p_phase;
		$changed(phase_o) |-> $past(lcd_tick_o);
	endproperty
	a_phase: assert property (p_phase) else $error("phase moved without tick");
	property p_com;
		$changed(com_index_o) |-> $past(lcd_tick_o);
	endproperty
	a_com: assert property (p_com) else $error("common moved without tick");
	property p_frame;
		frame_start_o |=> !frame_start_o;
	endproperty
	a_frame: assert property (p_frame) else $error("frame pulse too long");
	// reset itself is the cause here, so the default disable must not apply
	property p_rst;
		disable iff (1'b0) rst_i |=> seg_write_allow_o && !phase_o && com_index_o == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs wrong in reset");
endmodule
bind lcdpc_top lcdpc_checker u_chk(.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .lcd_tick_o,
	.com_index_o, .phase_o, .frame_start_o, .seg_write_allow_o);

// *** sim/lcdpc_top_bench.sv ***
/* lcdpc_top_bench: wishbone register and prescaler checks of lcdpc_top.
   assumes lcdpc_checker is bound and the glass model times ticks. */
`timescale 1ns/100ps
module lcdpc_top_bench import lcdpc_pkg::*;;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, tick, wa;
	logic [3:0] adr = 0;
	logic [31:0] wdat = 0, rd_dat, dat_o;
	logic [7:0] gap;
	int n_errors = 0, cmp_count = 0;
	lcdpc_top dut(.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .lcd_tick_o(tick),
		.com_index_o(), .phase_o(), .frame_start_o(), .seg_write_allow_o(wa));
	lcdpc_glass_model glass(.clk_i, .tick_i(tick), .gap_o(gap));
	always #5 clk_i = ~clk_i;
	task automatic conclude();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 40);
		if (ack !== 1'b1) begin
			n_errors++;
			conclude();
		end
		rd_dat = dat_o;
		cyc <= 1'b0;
	endtask
	task automatic t_regs();
		wb(0, LCDPC_PHASE_CTRL_OFS, 0);
		chk("reset", 32'h10, rd_dat);
		chk("wa", 1, wa);
		wb(1, LCDPC_PHASE_CTRL_OFS, 32'hff);
		wb(0, LCDPC_PHASE_CTRL_OFS, 0);
		chk("ro", 32'hdf, rd_dat);
		wb(1, 4'h8, 32'hff);
		wb(0, 4'h8, 0);
		chk("unmapped", 0, rd_dat);
	endtask
	// type-A at 1:1 then type-B at 1:16; two commons with third bias
	task automatic t_run(input logic [7:0] v);
		wb(1, LCDPC_PHASE_CTRL_OFS, {24'h0, v});
		wb(1, LCDPC_DRV_CTRL_OFS, 32'h3);
		repeat (100) @(posedge clk_i);
		chk("gap", v[3:0] + 1, gap);
		wb(0, LCDPC_PHASE_CTRL_OFS, 0);
		chk("active", 1, rd_dat[5]);
		wb(1, LCDPC_DRV_CTRL_OFS, 0);
		repeat (100) @(posedge clk_i);
		wb(0, LCDPC_PHASE_CTRL_OFS, 0);
		chk("idle", 2'h1, rd_dat[5:4]);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_run(8'h00);
		t_run(8'h8f);
		conclude();
	end
endmodule
